//--- rtl/emd_pkg.sv
/*
 Shared constants of the disturbance-suppression and receive-config block:
 register indices, field positions, reset values and timing counts.
 Assumes a 20 MHz system clock and a 32-bit AHB-Lite register bus.
*/
package emd_pkg;
   // Register indices; byte address is four times the index
   localparam logic [7:0] EMD_IDX_DSC = 8'h05;
   localparam logic [7:0] EMD_IDX_SST = 8'h06;
   localparam logic [7:0] EMD_IDX_RC1 = 8'h0B;
   localparam logic [7:0] EMD_IDX_IRQ_STAT = 8'h10;
   localparam logic [7:0] EMD_IDX_IRQ_MASK = 8'h11;
   // Reset values
   localparam logic [7:0] EMD_RST_DSC = 8'h00;
   localparam logic [7:0] EMD_RST_SST = 8'h00;
   localparam logic [7:0] EMD_RST_RC1 = 8'h00;
   // Writable bits of each register
   localparam logic [7:0] EMD_WMASK_DSC = 8'hCF;
   localparam logic [7:0] EMD_WMASK_SST = 8'h1F;
   localparam logic [7:0] EMD_WMASK_RC1 = 8'hFF;
   // Field positions
   localparam int EMD_DSC_EN = 7;
   localparam int EMD_DSC_TOL = 6;
   localparam int EMD_RC1_CHSEL = 7;
   // Interrupt status bit positions
   localparam int EMD_IRQ_W = 4;
   localparam int EMD_IRQ_RXS = 0;
   localparam int EMD_IRQ_SOFT = 1;
   localparam int EMD_IRQ_RESTART = 2;
   localparam int EMD_IRQ_FERR = 3;
   // Quarter etu at 106 kb/s (32 carrier periods) in ns, and clock period
   localparam int EMD_QETU_NS = 2360;
   localparam int EMD_CLK_NS = 50;
   // Longest time inside the step, so round down
   localparam int EMD_QETU_CYC = EMD_QETU_NS / EMD_CLK_NS;
   // AHB transfer type bit that marks an active transfer
   localparam int EMD_HTRANS_ACT = 1;
endpackage

//--- rtl/emd_rx_config.sv
/*
 Receive-side disturbance suppression and receiver configuration.
 Holds three byte registers plus interrupt status and mask on AHB-Lite,
 judges receive start, short-frame suppression and the subcarrier start
 check. Assumes frame events come from receive logic on hclk.
*/
// Design decision made here: the AHB-Lite interface to the registers.
// Operation
// - Suppression acts only while enable bit set
// - Tolerance 0: A106 start needs error-free first nibble
// - Tolerance 1: start despite nibble error, A106
// - Short erroneous frame below threshold is suppressed
// - Start time field counts quarter etu steps
// - Start time check only for B 106k
// - Early subcarrier without suppression raises soft error
// - Early subcarrier with suppression: discard, restart
// - Channel select: 0 AM, 1 PM
// - One channel enabled: select picks powered one
// - Both enabled, manual: select picks framing
// - Low-pass code passed to filter unchanged
// - Four zero-setting bits drive analog path
// - Checksum skip accepts frames without checking
`timescale 1ns/1ps
module emd_rx_config
   import emd_pkg::*;
#(
   parameter int QETU_CYC = EMD_QETU_CYC
)(
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   input wire logic iso_a106,
   input wire logic iso_b106,
   input wire logic crc_skip,
   input wire logic first4_done,
   input wire logic first4_err,
   input wire logic mrt_expired,
   input wire logic subcarrier_seen,
   input wire logic frame_end,
   input wire logic frame_err,
   input wire logic crc_err,
   input wire logic [7:0] frame_len,
   input wire logic op_am_en,
   input wire logic op_pm_en,
   input wire logic manual_select,
   input wire logic auto_pick_pm,
   output logic rx_start,
   output logic frame_accept,
   output logic frame_suppress,
   output logic am_power,
   output logic pm_power,
   output logic framing_pm,
   output logic [2:0] lowpass_code,
   output logic zero_setting_high,
   output logic zero_setting_mid_high,
   output logic zero_setting_mid_low,
   output logic zero_setting_low,
   output logic irq
);
   localparam int QW = (QETU_CYC > 1) ? $clog2(QETU_CYC) : 1;

   logic [7:0] dsc; // Suppression config
   logic [7:0] sst; // Subcarrier start time
   logic [7:0] rc1; // Receiver config one
   logic [EMD_IRQ_W-1:0] irq_stat; // Sticky events
   logic [EMD_IRQ_W-1:0] irq_mask; // Interrupt enables
   logic wr_pend; // Write data phase pending
   logic rd_pend; // Read wait state pending
   logic [7:0] ph_idx; // Index latched at address phase
   logic armed; // Start time window open
   logic [QW-1:0] qdiv; // Quarter etu prescaler
   logic [4:0] qcnt; // Elapsed quarter etu, saturating

   // Address phase decode
   wire addr_ok = hsel && htrans[EMD_HTRANS_ACT] && hready;
   wire [7:0] a_idx = haddr[9:2];
   wire a_hit = haddr[31:10] == 22'h0;
   // Data phase write strobes
   wire wr_dsc = wr_pend && ph_idx == EMD_IDX_DSC;
   wire wr_sst = wr_pend && ph_idx == EMD_IDX_SST;
   wire wr_rc1 = wr_pend && ph_idx == EMD_IDX_RC1;
   wire wr_stat = wr_pend && ph_idx == EMD_IDX_IRQ_STAT;
   wire wr_mask = wr_pend && ph_idx == EMD_IDX_IRQ_MASK;

   // Config fields
   wire emd_en = dsc[EMD_DSC_EN];
   wire tol = dsc[EMD_DSC_TOL];
   wire [3:0] thld = dsc[3:0];
   wire channel_select = rc1[EMD_RC1_CHSEL];

   // Receive start decision
   wire start_ok = !iso_a106 || !first4_err || tol;
   wire start_ev = first4_done && start_ok;
   // Frame errors; checksum ignored while skip set
   wire any_err = frame_err || (crc_err && !crc_skip);
   wire short_fr = frame_len < {4'h0, thld};
   // Suppression only with enable set
   wire sup_short = frame_end && emd_en && any_err && short_fr;
   // Early subcarrier, B 106k only
   wire early = iso_b106 && armed && subcarrier_seen
      && qcnt < sst[4:0];
   wire early_soft = early && !emd_en;
   wire early_rst = early && emd_en;
   wire q_tick = qdiv == QW'(QETU_CYC - 1);

   // Event vector for the status register
   wire [EMD_IRQ_W-1:0] ev = {frame_end && any_err && !sup_short,
      early_rst || sup_short, early_soft, start_ev};
   wire [EMD_IRQ_W-1:0] next_stat =
      (irq_stat & ~(wr_stat ? hwdata[EMD_IRQ_W-1:0] : '0)) | ev;

   // Read mux, reserved bits zero
   wire [7:0] rd_byte =
      ph_idx == EMD_IDX_DSC ? dsc :
      ph_idx == EMD_IDX_SST ? sst :
      ph_idx == EMD_IDX_RC1 ? rc1 :
      ph_idx == EMD_IDX_IRQ_STAT ? {4'h0, irq_stat} :
      ph_idx == EMD_IDX_IRQ_MASK ? {4'h0, irq_mask} : 8'h00;

   // Channel power and framing selection
   wire one_ch = op_am_en ^ op_pm_en;
   // Single channel mode: the select bit picks which one is powered
   wire next_am = one_ch ? !channel_select : op_am_en;
   wire next_pm = one_ch ? channel_select : op_pm_en;
   wire next_fpm = one_ch ? channel_select :
      manual_select ? channel_select : auto_pick_pm;

   // Bus phase tracking and answer
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         wr_pend <= 1'b0;
         rd_pend <= 1'b0;
         ph_idx <= 8'h00;
         hreadyout <= 1'b1;
         hrdata <= 32'h0;
         hresp <= 1'b0;
      end
      else
      begin
         hresp <= 1'b0;
         wr_pend <= addr_ok && hwrite && a_hit;
         rd_pend <= addr_ok && !hwrite;
         // Reads insert one wait state
         hreadyout <= !(addr_ok && !hwrite);
         if (addr_ok)
            ph_idx <= a_hit ? a_idx : 8'hFF;
         if (rd_pend)
            hrdata <= {24'h0, rd_byte};
      end
   end

   // Software registers, reserved bits masked
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         dsc <= EMD_RST_DSC;
         sst <= EMD_RST_SST;
         rc1 <= EMD_RST_RC1;
         irq_mask <= '0;
      end
      else
      begin
         if (wr_dsc)
            dsc <= hwdata[7:0] & EMD_WMASK_DSC;
         if (wr_sst)
            sst <= hwdata[7:0] & EMD_WMASK_SST;
         if (wr_rc1)
            rc1 <= hwdata[7:0] & EMD_WMASK_RC1;
         if (wr_mask)
            irq_mask <= hwdata[EMD_IRQ_W-1:0];
      end
   end

   // Sticky status, set wins over clear
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         irq_stat <= '0;
         irq <= 1'b0;
      end
      else
      begin
         irq_stat <= next_stat;
         irq <= |(next_stat & irq_mask);
      end
   end

   // Quarter etu timer from mask-receive timer expiry
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         armed <= 1'b0;
         qdiv <= '0;
         qcnt <= 5'h00;
      end
      else if (mrt_expired)
      begin
         // Restart the window
         armed <= 1'b1;
         qdiv <= '0;
         qcnt <= 5'h00;
      end
      else
      begin
         // One check per window
         if (subcarrier_seen || frame_end)
            armed <= 1'b0;
         qdiv <= q_tick ? '0 : qdiv + 1'b1;
         if (q_tick && qcnt != 5'h1F)
            qcnt <= qcnt + 5'h01;
      end
   end

   // Frame verdict and channel outputs
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         rx_start <= 1'b0;
         frame_accept <= 1'b0;
         frame_suppress <= 1'b0;
         am_power <= 1'b0;
         pm_power <= 1'b0;
         framing_pm <= 1'b0;
      end
      else
      begin
         rx_start <= start_ev;
         frame_accept <= frame_end && !sup_short;
         frame_suppress <= sup_short || early_rst;
         am_power <= next_am;
         pm_power <= next_pm;
         framing_pm <= next_fpm;
      end
   end

   // Analog path controls come straight from the register
   assign lowpass_code = rc1[6:4];
   assign zero_setting_high = rc1[3];
   assign zero_setting_mid_high = rc1[2];
   assign zero_setting_mid_low = rc1[1];
   assign zero_setting_low = rc1[0];

   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);

   start_tol_a: assert property (
      first4_done && iso_a106 && first4_err && tol |=> rx_start)
      else $error("start missing under tolerance");
   start_strict_a: assert property (
      first4_done && iso_a106 && first4_err && !tol |=> !rx_start)
      else $error("start despite nibble error");
   suppress_off_a: assert property (
      frame_end && !emd_en |=> frame_accept && !frame_suppress)
      else $error("suppression while disabled");
   short_frame_a: assert property (
      frame_end && emd_en && frame_err && frame_len < {4'h0, thld}
      |=> frame_suppress && !frame_accept)
      else $error("short frame not suppressed");
   soft_err_a: assert property (
      early && !emd_en |=> irq_stat[EMD_IRQ_SOFT] && !frame_suppress)
      else $error("soft error not raised");
   restart_a: assert property (
      early && emd_en |=> irq_stat[EMD_IRQ_RESTART] && frame_suppress
      && !($rose(irq_stat[EMD_IRQ_SOFT])))
      else $error("restart not raised");
   b_only_a: assert property (
      subcarrier_seen && !iso_b106 |=> !$rose(irq_stat[EMD_IRQ_SOFT])
      || $past(frame_end))
      else $error("check outside B 106k");
   one_chan_a: assert property (
      op_am_en && !op_pm_en
      |=> (am_power == !$past(channel_select)) && (pm_power == $past(channel_select)))
      else $error("single channel wrong");
   crc_skip_a: assert property (
      frame_end && crc_skip && !frame_err |=> frame_accept)
      else $error("checksum not skipped");
   rsvd_zero_a: assert property (
      hreadyout && $past(rd_pend) && $past(ph_idx) == EMD_IDX_SST
      |-> hrdata[31:5] == 27'h0)
      else $error("reserved bits not zero");

   early_c: cover property (early && emd_en);
   short_c: cover property (sup_short);
   tol_c: cover property (first4_done && first4_err && tol && iso_a106);
   irq_c: cover property ($rose(irq));
endmodule

//--- dv/emd_card_model.sv
/*
 Model of the card side: receive events as the RF front end reports them.
 Assumes the bench calls its tasks; all events move just after hclk rises.
*/
`timescale 1ns/1ps
module emd_card_model(
   input wire logic hclk,
   output logic first4_done,
   output logic first4_err,
   output logic mrt_expired,
   output logic subcarrier_seen,
   output logic frame_end,
   output logic frame_err,
   output logic crc_err,
   output logic [7:0] frame_len
);
   // Quiet at start
   initial
   begin
      {first4_done, first4_err, mrt_expired, subcarrier_seen} = 4'h0;
      {frame_end, frame_err, crc_err, frame_len} = 11'h0;
   end
   // Opening nibble; qualifier flips once no longer valid
   task nib(input logic e);
      @(posedge hclk);
      first4_done <= 1'b1;
      first4_err <= e;
      @(posedge hclk);
      first4_done <= 1'b0;
      first4_err <= ~e;
   endtask
   // Frame end with its length and error flags
   task frame(input logic [7:0] n, input logic fe, input logic ce);
      @(posedge hclk);
      {frame_end, frame_err, crc_err, frame_len} <= {1'b1, fe, ce, n};
      @(posedge hclk);
      {frame_end, frame_err, crc_err, frame_len} <= {1'b0, ~fe, ~ce, ~n};
   endtask
   // Timer end, then subcarrier after a gap of g cycles
   task sub(input int g);
      @(posedge hclk);
      mrt_expired <= 1'b1;
      @(posedge hclk);
      mrt_expired <= 1'b0;
      repeat (g) @(posedge hclk);
      subcarrier_seen <= 1'b1;
      @(posedge hclk);
      subcarrier_seen <= 1'b0;
   endtask
endmodule

//--- dv/tb.sv
/*
 Bench for emd_rx_config: AHB-Lite register tasks and event scenarios.
 Assumes the card model drives receive events; quarter etu is 2 cycles.
*/
`timescale 1ns/1ps
module tb;
   import emd_pkg::*;
   logic hclk = 1'b0;
   logic hresetn = 1'b0;
   logic hsel = 1'b0;
   logic hwrite = 1'b0;
   logic [1:0] htrans = 2'h0;
   logic [31:0] haddr = 32'h0;
   logic [31:0] hwdata = 32'h0;
   logic [31:0] hrdata;
   logic hreadyout, hresp, rx_start, frame_accept, frame_suppress, irq;
   logic am_power, pm_power, framing_pm, zh, zmh, zml, zl;
   logic [2:0] lowpass_code;
   logic iso_a106 = 1'b0;
   logic iso_b106 = 1'b0;
   logic crc_skip = 1'b0;
   logic op_am_en = 1'b0;
   logic op_pm_en = 1'b0;
   logic manual_select = 1'b0;
   logic auto_pick_pm = 1'b0;
   logic [2:0] hsize = 3'h0;
   logic f4d, f4e, mask_receive_timer, sub, fe, ferr, cerr;
   logic [7:0] flen;
   int n_errors = 0;
   int comparisons = 0;
   int cyc = 0;
   int n_rxs = 0;
   int n_acc = 0;
   int n_sup = 0;
   emd_card_model card(.hclk(hclk), .first4_done(f4d), .first4_err(f4e), .mrt_expired(mask_receive_timer),
      .subcarrier_seen(sub), .frame_end(fe), .frame_err(ferr), .crc_err(cerr),
      .frame_len(flen));
   emd_rx_config #(.QETU_CYC(2)) dut(.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
      .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
      .iso_a106(iso_a106), .iso_b106(iso_b106), .crc_skip(crc_skip), .first4_done(f4d),
      .first4_err(f4e), .mrt_expired(mask_receive_timer), .subcarrier_seen(sub), .frame_end(fe),
      .frame_err(ferr), .crc_err(cerr), .frame_len(flen), .op_am_en(op_am_en),
      .op_pm_en(op_pm_en), .manual_select(manual_select), .auto_pick_pm(auto_pick_pm),
      .rx_start(rx_start), .frame_accept(frame_accept), .frame_suppress(frame_suppress),
      .am_power(am_power), .pm_power(pm_power), .framing_pm(framing_pm),
      .lowpass_code(lowpass_code), .zero_setting_high(zh), .zero_setting_mid_high(zmh),
      .zero_setting_mid_low(zml), .zero_setting_low(zl), .irq(irq));
   // Clock
   always #25 hclk = ~hclk;
   // Pulse tallies and hang limit
   always @(posedge hclk)
   begin
      cyc++;
      n_rxs += int'(rx_start === 1'b1);
      n_acc += int'(frame_accept === 1'b1);
      n_sup += int'(frame_suppress === 1'b1);
      if (cyc == 20000)
      begin
         n_errors++;
         report_and_stop();
      end
   end
   // Compare and report
   task chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp)
      begin
         n_errors++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // Verdict
   task report_and_stop;
      $display("errors=%0d comparisons=%0d", n_errors, comparisons);
      if (n_errors == 0 && comparisons > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   // One single transfer: address phase, then data phase
   task bus(input logic [7:0] i, input logic w, input logic [31:0] d, output logic [31:0] q);
      @(posedge hclk);
      {hsel, htrans, hwrite, haddr} <= {1'b1, 2'h2, w, 22'h0, i, 2'h0};
      hsize <= 3'h2;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      {hsel, htrans, hwdata} <= {1'b0, 2'h0, d};
      do @(posedge hclk); while (hreadyout !== 1'b1);
      q = hrdata;
   endtask
   task wr(input logic [7:0] i, input logic [31:0] d);
      logic [31:0] q;
      bus(i, 1'b1, d, q);
   endtask
   task rd(input logic [7:0] i, input logic [31:0] e);
      logic [31:0] q;
      bus(i, 1'b0, 32'h0, q);
      chk(q, e);
      chk(32'(hresp), 32'h0);
   endtask
   // Running pulse totals
   task ev(input int r, input int a, input int s);
      repeat (3) @(posedge hclk);
      chk(32'(n_rxs), 32'(r));
      chk(32'(n_acc), 32'(a));
      chk(32'(n_sup), 32'(s));
   endtask
   // Look at a level output; the caller waits for it to settle
   task lvl(input logic [31:0] got, input logic [31:0] exp);
      chk(got, exp);
   endtask
   // Main sequence
   initial
   begin
      repeat (4) @(posedge hclk);
      hresetn <= 1'b1;
      rd(EMD_IDX_DSC, 32'h0);
      rd(EMD_IDX_SST, 32'h0);
      rd(EMD_IDX_RC1, 32'h0);
      rd(8'h3F, 32'h0);
      wr(EMD_IDX_DSC, 32'hFF);
      rd(EMD_IDX_DSC, 32'hCF);
      wr(EMD_IDX_SST, 32'hFF);
      rd(EMD_IDX_SST, 32'h1F);
      wr(EMD_IDX_RC1, 32'hA5);
      op_am_en <= 1'b1;
      repeat (2) @(posedge hclk);
      lvl(32'(lowpass_code), 32'h2);
      lvl(32'({zh, zmh, zml, zl}), 32'h5);
      lvl(32'({am_power, pm_power}), 32'h1);
      {op_pm_en, manual_select} <= 2'h3;
      repeat (2) @(posedge hclk);
      lvl(32'(framing_pm), 32'h1);
      lvl(32'({am_power, pm_power}), 32'h3);
      wr(EMD_IDX_RC1, 32'h25);
      repeat (2) @(posedge hclk);
      lvl(32'(framing_pm), 32'h0);
      // Automatic choice takes over once manual selection is off
      {manual_select, auto_pick_pm} <= 2'h1;
      repeat (2) @(posedge hclk);
      lvl(32'(framing_pm), 32'h1);
      // Host enables suppression with skips clear, threshold 4
      wr(EMD_IDX_DSC, 32'h84);
      iso_a106 <= 1'b1;
      card.nib(1'b1);
      ev(0, 0, 0);
      card.nib(1'b0);
      ev(1, 0, 0);
      wr(EMD_IDX_DSC, 32'hC4);
      card.nib(1'b1);
      ev(2, 0, 0);
      wr(EMD_IDX_DSC, 32'h84);
      iso_a106 <= 1'b0;
      card.nib(1'b1);
      ev(3, 0, 0);
      card.frame(8'h3, 1'b1, 1'b0);
      ev(3, 0, 1);
      card.frame(8'h4, 1'b1, 1'b0);
      ev(3, 1, 1);
      card.frame(8'h3, 1'b0, 1'b1);
      ev(3, 1, 2);
      crc_skip <= 1'b1;
      card.frame(8'h3, 1'b0, 1'b1);
      ev(3, 2, 2);
      wr(EMD_IDX_DSC, 32'h44);
      card.frame(8'h3, 1'b1, 1'b0);
      ev(3, 3, 2);
      // Subcarrier start check, 8 quarter etu
      wr(EMD_IDX_IRQ_STAT, 32'hF);
      wr(EMD_IDX_SST, 32'h8);
      iso_b106 <= 1'b1;
      card.sub(2);
      rd(EMD_IDX_IRQ_STAT, 32'h2);
      lvl(32'(irq), 32'h0);
      wr(EMD_IDX_IRQ_MASK, 32'hF);
      repeat (2) @(posedge hclk);
      lvl(32'(irq), 32'h1);
      wr(EMD_IDX_IRQ_STAT, 32'hF);
      repeat (2) @(posedge hclk);
      lvl(32'(irq), 32'h0);
      wr(EMD_IDX_DSC, 32'hC4);
      card.sub(2);
      rd(EMD_IDX_IRQ_STAT, 32'h4);
      wr(EMD_IDX_IRQ_STAT, 32'hF);
      card.sub(30);
      rd(EMD_IDX_IRQ_STAT, 32'h0);
      iso_b106 <= 1'b0;
      card.sub(2);
      rd(EMD_IDX_IRQ_STAT, 32'h0);
      report_and_stop();
   end
endmodule
